//--- rtl/spu_pkg.sv
// shared constants and types of the sram clock unlock host controller
`default_nettype none
package spu_pkg;
  // ****************************************************************
  // register map (byte addresses on the avalon slave)
  // ****************************************************************
  localparam logic [4:0] SPU_REG_CTRL   = 5'h00; // command pulses
  localparam logic [4:0] SPU_REG_STATUS = 5'h04; // busy, done, power fail
  localparam logic [4:0] SPU_REG_SCR    = 5'h08; // scratch address, memory write byte
  localparam logic [4:0] SPU_REG_WR_LO  = 5'h0C; // clock image to write, regs 0..3
  localparam logic [4:0] SPU_REG_WR_HI  = 5'h10; // clock image to write, regs 4..7
  localparam logic [4:0] SPU_REG_RD_LO  = 5'h14; // clock image read back, regs 0..3
  localparam logic [4:0] SPU_REG_RD_HI  = 5'h18; // clock image read back, regs 4..7
  localparam logic [4:0] SPU_REG_MEM    = 5'h1C; // last memory read byte
  // ctrl and status field positions
  localparam int SPU_CTRL_CLK_RD = 0;
  localparam int SPU_CTRL_CLK_WR = 1;
  localparam int SPU_CTRL_MEM_RD = 2;
  localparam int SPU_CTRL_MEM_WR = 3;
  localparam int SPU_ST_BUSY     = 0;
  localparam int SPU_ST_DONE     = 1;
  localparam int SPU_ST_PF_ERR   = 2;
  localparam int SPU_ST_PF_LVL   = 3;
  // reset value of the scratch register
  localparam logic [22:0] SPU_SCR_RST = 23'h00_7FFF;
  // ****************************************************************
  // unlock key: first byte sent sits in bits 7:0, each byte lsb first
  // ****************************************************************
  localparam logic [63:0] SPU_KEY      = 64'h5CA3_3AC5_5CA3_3AC5;
  localparam logic [5:0]  SPU_LAST_BIT = 6'h3F;  // 64 bits per phase
  // ****************************************************************
  // bus cycle timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETUP_NS      = 10; // address setup before the strobes
  localparam int STROBE_NS     = 70; // strobe low width, covers access delays
  localparam int RECOV_NS      = 20; // write_recovery_time, strobes high
  localparam logic [4:0] SPU_SETUP_CYC  = 5'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] SPU_STROBE_CYC = 5'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] SPU_RECOV_CYC  = 5'((RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic        is_write; // write cycle when high
    logic [14:0] addr;     // address_inputs
    logic [7:0]  wdata;    // byte driven on writes
  } spu_req_t;
  typedef struct packed {
    logic        ce_n;     // chip select, active low
    logic        oe_n;     // output enable, active low
    logic        we_n;     // write strobe, active low
    logic [14:0] addr;     // address_inputs, bit 14 is top_address_or_abort_pin
    logic [7:0]  dq;       // data out
    logic        dq_oe_n;  // low while we drive the data pins
  } spu_pins_t;
endpackage : spu_pkg
`default_nettype wire

//--- rtl/spu_bus_cycle.sv
// one asynchronous sram bus cycle, read or write, on the memory pins
`default_nettype none
module spu_bus_cycle #(
  parameter logic [4:0] SETUP_CYC  = spu_pkg::SPU_SETUP_CYC,
  parameter logic [4:0] STROBE_CYC = spu_pkg::SPU_STROBE_CYC,
  parameter logic [4:0] RECOV_CYC  = spu_pkg::SPU_RECOV_CYC
) (
  // clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  // request side
  input  wire logic               start_i,
  input  wire logic               abort_i,
  input  wire spu_pkg::spu_req_t  req_i,
  output logic                    busy_o,
  output logic                    done_o,
  output logic [7:0]              rdata_o,
  // memory pins
  input  wire logic [7:0]         dq_i,
  output spu_pkg::spu_pins_t      pins_o
);
  import spu_pkg::*;
  // ****************************************************************
  // cycle sequencer
  // ****************************************************************
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_RECOV} spu_cy_t;
  spu_cy_t     state_ff, nxt_state;  // cycle phase
  logic [4:0]  cnt_ff, nxt_cnt;      // cycles left in phase
  spu_req_t    req_ff;               // request held for the whole cycle
  logic        last;                 // final cycle of the phase

  assign last   = (cnt_ff == 5'h00);
  assign busy_o = (state_ff != CY_IDLE);

  // next phase; abort drops the strobes at once
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = last ? 5'h00 : cnt_ff - 5'h01;
    case (state_ff)
      CY_IDLE:
      begin
        nxt_cnt = SETUP_CYC - 5'h01;
        if (start_i)
          nxt_state = CY_SETUP;
      end
      CY_SETUP:
        if (last)
        begin
          nxt_state = CY_STROBE;
          nxt_cnt   = STROBE_CYC - 5'h01;
        end
      CY_STROBE:
        if (last)
        begin
          nxt_state = CY_RECOV;
          nxt_cnt   = RECOV_CYC - 5'h01;
        end
      CY_RECOV:
        if (last)
          nxt_state = CY_IDLE;
      default:
        nxt_state = CY_IDLE;
    endcase
    if (abort_i)
      nxt_state = CY_IDLE;
  end

  // phase registers
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= CY_IDLE;
      cnt_ff   <= 5'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // request latch; address stays put through setup, strobe and recovery
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      req_ff <= '0;
    else if (state_ff == CY_IDLE && start_i)
      req_ff <= req_i;
  end

  // ****************************************************************
  // pins, registered so no strobe glitches
  // ****************************************************************
  // select and write strobe fall and rise together, so the write window is
  // exactly the strobe phase output enable stays high on writes
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pins_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 15'h0000,
                  dq: 8'h00, dq_oe_n: 1'b1};
    end
    else
    begin
      pins_o.ce_n    <= !(nxt_state == CY_STROBE);
      pins_o.oe_n    <= !(nxt_state == CY_STROBE && !nxt_req().is_write);
      pins_o.we_n    <= !(nxt_state == CY_STROBE && nxt_req().is_write);
      pins_o.addr    <= nxt_req().addr;
      pins_o.dq      <= nxt_req().wdata;
      // data held through recovery as hold time after the strobe rises
      pins_o.dq_oe_n <= !(nxt_state != CY_IDLE && nxt_req().is_write);
    end
  end

  // request that the pins reflect in the coming cycle
  function automatic spu_req_t nxt_req();
    return (state_ff == CY_IDLE) ? req_i : req_ff;
  endfunction

  // read data sampled on the last strobe cycle, then a done pulse
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 8'h00;
      done_o  <= 1'b0;
    end
    else
    begin
      if (state_ff == CY_STROBE && last && !req_ff.is_write)
        rdata_o <= dq_i;
      done_o <= (state_ff == CY_RECOV) && last && !abort_i;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  localparam int CY_MAX = 40;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_oe_off_in_write;
    !pins_o.we_n |-> pins_o.oe_n && !pins_o.dq_oe_n;
  endproperty
  a_oe_off_in_write: assert property (p_oe_off_in_write) else $error("oe low in write");

  property p_addr_stable;
    (state_ff != CY_IDLE && $past(state_ff) != CY_IDLE) |-> $stable(pins_o.addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in cycle");

  property p_recovery;
    ($rose(pins_o.we_n) && !abort_i) |-> pins_o.we_n [*5];
  endproperty
  a_recovery: assert property (p_recovery) else $error("write recovery too short");

  property p_done_bound;
    (state_ff == CY_IDLE && start_i && !abort_i) |-> ##[1:CY_MAX] (done_o || abort_i);
  endproperty
  a_done_bound: assert property (p_done_bound) else $error("bus cycle never ended");
endmodule : spu_bus_cycle
`default_nettype wire

//--- rtl/spu_host_ctrl.sv
// host controller that unlocks and streams the clock behind an sram
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`default_nettype none
module spu_host_ctrl (
  // clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  // avalon-mm slave
  input  wire logic [4:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  output logic [31:0]              avs_readdata_o,
  output logic                     avs_waitrequest_o,
  // memory pins and supply sense
  input  wire logic [7:0]          dq_i,
  input  wire logic                power_fail_threshold_i,
  output spu_pkg::spu_pins_t       sram_o
);
  import spu_pkg::*;
  // ****************************************************************
  // declarations
  // ****************************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_MEM, ST_PTR_RD, ST_KEY, ST_XFER} spu_st_t;
  spu_st_t      st_ff;          // sequence state
  logic [5:0]   cnt_ff;         // bit index in key or data phase
  logic         op_write_ff;    // clock transfer direction, or memory direction
  logic         start_ff;       // launch one bus cycle
  logic         done_ff;        // sticky completion flag
  logic         pf_err_ff;      // sticky power fail refusal
  logic [22:0]  scr_ff;         // scratch address and memory write byte
  logic [63:0]  wr_img_ff;      // clock image to write
  logic [63:0]  rd_img_ff;      // clock image read back
  logic [7:0]   mem_rd_ff;      // last memory read byte
  logic         ack_ff;         // bus answer phase
  logic         eng_busy;       // bus cycle in progress
  logic         eng_done;       // bus cycle finished
  logic [7:0]   eng_rdata;      // byte seen on the read strobe
  logic         wr_ctrl;        // ctrl write accepted this edge
  logic         accept;         // command may start
  spu_req_t     req;            // request for the next bus cycle

  // ****************************************************************
  // avalon slave: one wait cycle, then answer
  // ****************************************************************
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;
  assign wr_ctrl = avs_write_i && ack_ff && (avs_address_i == SPU_REG_CTRL);
  assign accept  = wr_ctrl && (st_ff == ST_IDLE) && !power_fail_threshold_i;

  // answer phase and read data capture
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ack_ff         <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= (avs_read_i || avs_write_i) && !ack_ff;
      if (avs_read_i && !ack_ff)
        case (avs_address_i)
          SPU_REG_STATUS: avs_readdata_o <= {28'h000_0000, power_fail_threshold_i,
                                             pf_err_ff, done_ff, (st_ff != ST_IDLE) || eng_busy};
          SPU_REG_SCR:    avs_readdata_o <= {9'h000, scr_ff};
          SPU_REG_WR_LO:  avs_readdata_o <= wr_img_ff[31:0];
          SPU_REG_WR_HI:  avs_readdata_o <= wr_img_ff[63:32];
          SPU_REG_RD_LO:  avs_readdata_o <= rd_img_ff[31:0];
          SPU_REG_RD_HI:  avs_readdata_o <= rd_img_ff[63:32];
          SPU_REG_MEM:    avs_readdata_o <= {24'h00_0000, mem_rd_ff};
          default:        avs_readdata_o <= 32'h0000_0000; // ctrl and unmapped
        endcase
    end
  end

  // software written registers; half-image writes keep bytes whole
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      scr_ff    <= SPU_SCR_RST;
      wr_img_ff <= 64'h0000_0000_0000_0000;
    end
    else if (avs_write_i && ack_ff)
      case (avs_address_i)
        SPU_REG_SCR:   scr_ff            <= avs_writedata_i[22:0];
        SPU_REG_WR_LO: wr_img_ff[31:0]  <= avs_writedata_i;
        SPU_REG_WR_HI: wr_img_ff[63:32] <= avs_writedata_i;
        default:       scr_ff            <= scr_ff;
      endcase
  end

  // ****************************************************************
  // next bus cycle
  // ****************************************************************
  // one scratch address for every unlock and data cycle bit 14 is
  // held high there so the abort pin stays inactive the key byte
  // also lands in that scratch byte
  always_comb
  begin
    req = '{is_write: 1'b0, addr: {1'b1, scr_ff[13:0]}, wdata: 8'h00};
    case (st_ff)
      ST_MEM:
      begin
        req.is_write = op_write_ff;
        req.addr     = scr_ff[14:0];
        req.wdata    = scr_ff[22:15];
      end
      ST_PTR_RD:
        req.is_write = 1'b0;
      ST_KEY:
      begin
        req.is_write = 1'b1;
        req.wdata    = {7'h00, SPU_KEY[cnt_ff]};
      end
      ST_XFER:
      begin
        req.is_write = op_write_ff;
        req.wdata    = {7'h00, wr_img_ff[cnt_ff]};
      end
      default:
        req.is_write = 1'b0;
    endcase
  end

  // ****************************************************************
  // sequence: pointer read, 64 key writes, 64 data cycles
  // ****************************************************************
  // no other cycles are interleaved, so the pointer never sees a stray read
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st_ff       <= ST_IDLE;
      cnt_ff      <= 6'h00;
      op_write_ff <= 1'b0;
      start_ff    <= 1'b0;
    end
    else
    begin
      start_ff <= 1'b0;
      if (power_fail_threshold_i)
        st_ff <= ST_IDLE;
      else
        case (st_ff)
          ST_IDLE:
            if (accept)
            begin
              cnt_ff   <= 6'h00;
              start_ff <= 1'b1;
              if (avs_writedata_i[SPU_CTRL_CLK_RD] || avs_writedata_i[SPU_CTRL_CLK_WR])
              begin
                st_ff       <= ST_PTR_RD;
                op_write_ff <= avs_writedata_i[SPU_CTRL_CLK_WR];
              end
              else if (avs_writedata_i[SPU_CTRL_MEM_RD] || avs_writedata_i[SPU_CTRL_MEM_WR])
              begin
                st_ff       <= ST_MEM;
                op_write_ff <= avs_writedata_i[SPU_CTRL_MEM_WR];
              end
              else
                start_ff <= 1'b0;
            end
          ST_MEM:
            if (eng_done)
              st_ff <= ST_IDLE;
          ST_PTR_RD:
            if (eng_done)
            begin
              st_ff    <= ST_KEY;
              start_ff <= 1'b1;
            end
          ST_KEY:
            if (eng_done)
            begin
              start_ff <= 1'b1;
              cnt_ff   <= cnt_ff + 6'h01;
              if (cnt_ff == SPU_LAST_BIT)
                st_ff <= ST_XFER;
            end
          ST_XFER:
            if (eng_done)
            begin
              cnt_ff <= cnt_ff + 6'h01;
              if (cnt_ff == SPU_LAST_BIT)
                st_ff <= ST_IDLE;
              else
                start_ff <= 1'b1;
            end
          default:
            st_ff <= ST_IDLE;
        endcase
    end
  end

  // read back images and status flags; completion set wins over clear
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rd_img_ff <= 64'h0000_0000_0000_0000;
      mem_rd_ff <= 8'h00;
      done_ff   <= 1'b0;
      pf_err_ff <= 1'b0;
    end
    else
    begin
      if (eng_done && st_ff == ST_XFER && !op_write_ff)
        rd_img_ff[cnt_ff] <= eng_rdata[0];
      if (eng_done && st_ff == ST_MEM && !op_write_ff)
        mem_rd_ff <= eng_rdata;
      if (wr_ctrl)
      begin
        done_ff   <= 1'b0;
        pf_err_ff <= 1'b0;
      end
      if (eng_done && (st_ff == ST_MEM || (st_ff == ST_XFER && cnt_ff == SPU_LAST_BIT)))
        done_ff <= 1'b1;
      if (power_fail_threshold_i && (st_ff != ST_IDLE || wr_ctrl))
        pf_err_ff <= 1'b1;
    end
  end

  // ****************************************************************
  // bus cycle engine
  // ****************************************************************
  spu_bus_cycle u_cycle (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .start_i    (start_ff),
    .abort_i    (power_fail_threshold_i),
    .req_i      (req),
    .busy_o     (eng_busy),
    .done_o     (eng_done),
    .rdata_o    (eng_rdata),
    .dq_i       (dq_i),
    .pins_o     (sram_o)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_ptr_first;
    $rose(st_ff == ST_KEY) |-> $past(st_ff) == ST_PTR_RD && $past(eng_done);
  endproperty
  a_ptr_first: assert property (p_ptr_first) else $error("key without pointer read");

  property p_key_bit;
    (st_ff == ST_KEY && !sram_o.we_n) |-> sram_o.dq[0] == SPU_KEY[cnt_ff];
  endproperty
  a_key_bit: assert property (p_key_bit) else $error("wrong key bit on pin");

  property p_key_count;
    (st_ff == ST_XFER && $past(st_ff) == ST_KEY) |-> $past(cnt_ff) == 6'h3F;
  endproperty
  a_key_count: assert property (p_key_count) else $error("data phase before 64 key writes");

  property p_abort_pin_high;
    (st_ff inside {ST_KEY, ST_XFER} && !sram_o.ce_n) |-> sram_o.addr[14];
  endproperty
  a_abort_pin_high: assert property (p_abort_pin_high) else $error("abort pin low in transfer");

  property p_pfail;
    (power_fail_threshold_i && st_ff != ST_IDLE) |=> st_ff == ST_IDLE ##1 sram_o.ce_n;
  endproperty
  a_pfail: assert property (p_pfail) else $error("access under power fail");

  property p_xfer_end;
    ($past(st_ff) == ST_XFER && st_ff == ST_IDLE && !$past(power_fail_threshold_i))
      |-> $past(cnt_ff) == 6'h3F && done_ff;
  endproperty
  a_xfer_end: assert property (p_xfer_end) else $error("transfer ended early");

  c_clk_read:  cover property ($fell(st_ff == ST_XFER) && !op_write_ff && done_ff);
  c_clk_write: cover property ($fell(st_ff == ST_XFER) && op_write_ff && done_ff);
  c_mem_read:  cover property (st_ff == ST_MEM && eng_done && !op_write_ff);
  c_pf_abort:  cover property (power_fail_threshold_i && st_ff == ST_KEY);
endmodule : spu_host_ctrl
`default_nettype wire

//--- tb/spu_dev_model.sv
// behavioural sram with the hidden serial clock, seen from the pins
`default_nettype none
module spu_dev_model (
  // clock, reset and supply sense
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  input  wire logic               pf_i,
  // memory pins
  input  wire spu_pkg::spu_pins_t pins_i,
  output logic [7:0]              dq_o,
  output logic                    err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import spu_pkg::*;
  // ****************************************************************
  // state
  // ****************************************************************
  localparam logic [63:0] KEY = {2{8'h5C, 8'hA3, 8'h3A, 8'hC5}};
  logic [7:0]  mem [0:32767]; // one byte per address
  logic [63:0] regs_ff;       // eight bcd registers, reg n in bits 8n+7:8n
  logic [5:0]  ptr_ff;        // key pointer or data bit index
  logic        hunt_ff;       // key comparison armed
  logic        ok_ff;         // no mismatch yet
  logic        data_ff;       // 64 clock data cycles in progress
  logic        prev_ff;       // select level at the last edge
  logic        wr_ff;         // write overlap seen in this cycle
  logic [14:0] ad_ff;         // address of this cycle
  logic [7:0]  wd_ff;         // data taken during the overlap
  logic [7:0]  last_ff;       // last wire level
  logic [7:0]  dev_q;
  logic        dev_en;
  // drivers off while the write strobe is low or supply fails
  assign dev_en = !pins_i.ce_n && !pins_i.oe_n && pins_i.we_n && !pf_i;
  assign dev_q  = data_ff ? {7'h00, regs_ff[ptr_ff]} : mem[pins_i.addr];
  // released bus shows the inverse of its last level: there is no pull
  assign dq_o = !pins_i.dq_oe_n ? pins_i.dq : dev_en ? dev_q : ~last_ff;
  // ****************************************************************
  // cycle tracking, commit at the rising select edge
  // ****************************************************************
  always_ff @(posedge core_clk_i)
  begin
    last_ff <= dq_o;
    prev_ff <= pins_i.ce_n;
    if (rst_i)
    begin
      prev_ff <= 1'b1;
      wr_ff   <= 1'b0;
      hunt_ff <= 1'b0;
      data_ff <= 1'b0;
      err_o   <= 1'b0;
      regs_ff <= 64'h0000_0030_0000_0000; // day control bits set
    end
    else if (!pins_i.ce_n)
    begin
      ad_ff <= pins_i.addr;
      // write lasts only while both strobes are low
      if (!pins_i.we_n)
      begin
        wr_ff <= 1'b1;
        wd_ff <= dq_o;
      end
      // address must hold, outputs must stay off in writes
      if ((!prev_ff && pins_i.addr != ad_ff) || (!pins_i.oe_n && !pins_i.we_n))
        err_o <= 1'b1;
      // abort pin low ends a transfer while day bit 4 is clear
      if (data_ff && !regs_ff[36] && !pins_i.addr[14])
        data_ff <= 1'b0;
    end
    // only our own select's cycles step the sequence; anything done while
    // select is high leaves pointer and transfer alone
    else if (!prev_ff && !pf_i)
    begin
      wr_ff <= 1'b0;
      if (wr_ff && !data_ff)
        mem[ad_ff] <= wd_ff; // unlock writes land too
      if (data_ff)
      begin
        if (wr_ff)
          regs_ff[ptr_ff] <= wd_ff[0];
        ptr_ff  <= ptr_ff + 6'h01;
        data_ff <= (ptr_ff != 6'h3F); // relock after 64
      end
      else if (!wr_ff)
      begin
        hunt_ff <= 1'b1; // any read restarts
        ok_ff   <= 1'b1;
        ptr_ff  <= 6'h00;
      end
      else if (hunt_ff && ok_ff && wd_ff[0] == KEY[ptr_ff])
      begin
        ptr_ff  <= ptr_ff + 6'h01;
        data_ff <= (ptr_ff == 6'h3F);
        hunt_ff <= (ptr_ff != 6'h3F);
      end
      else
        ok_ff <= 1'b0; // mismatch freezes
    end
    else if (!prev_ff)
      wr_ff <= 1'b0; // blocked below the threshold
  end
endmodule // spu_dev_model
`default_nettype wire

//--- tb/spu_host_ctrl_test.sv
// self-checking bench for the sram clock host controller
`default_nettype none
module spu_host_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import spu_pkg::*;
  logic        clk, rst, rd, wr, avs_wait, pf, perr;
  logic [4:0]  addr;
  logic [31:0] wdat, rdat, got, lo, hi;
  logic [7:0]  dq, b;
  logic [14:0] a;
  spu_pins_t   pins;
  int          errors, samples_checked, cyc;
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  spu_host_ctrl dut (.core_clk_i(clk), .rst_i(rst), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(avs_wait), .dq_i(dq), .power_fail_threshold_i(pf), .sram_o(pins));
  spu_dev_model u_dev (.core_clk_i(clk), .rst_i(rst), .pf_i(pf), .pins_i(pins),
    .dq_o(dq), .err_o(perr));
  // hang guard, well above the three clock sequences
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic av(input logic w, input logic [4:0] ad, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= ad;
    wdat <= d;
    rd   <= !w;
    wr   <= w;
    do @(posedge clk); while (avs_wait !== 1'b0 && ++n < 100);
    if (n == 100)
      errors++;
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // issue a command and poll status until done
  task automatic run(input logic [31:0] c);
    int n;
    n = 0;
    av(1'b1, SPU_REG_CTRL, c, got);
    do av(1'b0, SPU_REG_STATUS, 32'h0, got); while (got[SPU_ST_DONE] !== 1'b1 && ++n < 3000);
    chk(got & 32'h3, 32'h2);
  endtask
  initial
  begin
    {rst, rd, wr, pf, addr, wdat} = {4'h8, 5'h00, 32'h0};
    void'($urandom(32'hC424C208));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    av(1'b0, SPU_REG_STATUS, 32'h0, got);
    chk(got, 32'h0);
    av(1'b0, SPU_REG_SCR, 32'h0, got);
    chk(got, 32'(SPU_SCR_RST));
    // memory traffic, both address extremes first
    for (int i = 0; i < 4; i++)
    begin
      a = (i == 0) ? 15'h7FFF : (i == 1) ? 15'h0000 : 15'($urandom);
      b = 8'($urandom);
      av(1'b1, SPU_REG_SCR, {9'h000, b, a}, got);
      run(32'h8);
      chk(32'(u_dev.mem[a]), 32'(b));
      run(32'h4);
      av(1'b0, SPU_REG_MEM, 32'h0, got);
      chk(got, 32'(b));
    end
    // poison the scratch byte, then write the clock
    a = {1'b1, 14'($urandom)};
    av(1'b1, SPU_REG_SCR, {9'h000, 8'hFF, a}, got);
    run(32'h8);
    lo = $urandom;
    hi = $urandom;
    av(1'b1, SPU_REG_WR_LO, lo, got);
    av(1'b1, SPU_REG_WR_HI, hi, got);
    run(32'h2);
    chk(u_dev.regs_ff[31:0], lo);
    chk(u_dev.regs_ff[63:32], hi);
    chk(32'(u_dev.mem[a][0]), 32'h0);
    chk(32'(u_dev.data_ff), 32'h0);
    // supply fails in the middle of the unlock of a clock read
    av(1'b1, SPU_REG_CTRL, 32'h1, got);
    repeat (600) @(posedge clk);
    pf <= 1'b1;
    repeat (4) @(posedge clk);
    av(1'b0, SPU_REG_STATUS, 32'h0, got);
    chk(got & 32'hD, 32'hC);
    av(1'b1, SPU_REG_CTRL, 32'h1, got);
    av(1'b0, SPU_REG_STATUS, 32'h0, got);
    chk(got & 32'h1, 32'h0);
    // the aborted read must have left the read image at its reset value
    av(1'b0, SPU_REG_RD_LO, 32'h0, got);
    chk(got, 32'h0);
    av(1'b0, SPU_REG_RD_HI, 32'h0, got);
    chk(got, 32'h0);
    pf <= 1'b0;
    run(32'h1);
    av(1'b0, SPU_REG_RD_LO, 32'h0, got);
    chk(got, lo);
    av(1'b0, SPU_REG_RD_HI, 32'h0, got);
    chk(got, hi);
    chk(32'(perr), 32'h0);
    summarize();
  end
endmodule // spu_host_ctrl_test
`default_nettype wire
